// ---- include/ppc_pkg.sv ----
// shared constants and types for the port pin control block
package ppc_pkg;
    // ====================================================
    // port widths
    localparam int ARB_W = 8;
    localparam int CPA_W = 8;
    localparam int CPB_W = 8;
    localparam int CAP_W = 16;
    localparam int TMR_W = 16;
    localparam int AIN_W = 16;
    localparam int AIN_SEL_W = 4;

    // ====================================================
    // implemented-bit masks
    localparam logic [7:0] FULL8_MASK = 8'hFF;
    localparam logic [15:0] FULL16_MASK = 16'hFFFF;
    localparam int ABSENT_BIT_FOURTEEN = 14;
    localparam logic [15:0] TMR_IMPL_MASK = 16'hBFFF;

    // ====================================================
    // alternate function bit positions
    localparam int TMR_HIGHBYTE_BIT = 12;
    localparam int TMR_CLK_BIT = 15;
    localparam int ARB_CS_LSB = 0;
    localparam int ARB_CS_N = 5;
    localparam int ARB_HOLD_BIT = 5;
    localparam int ARB_HOLD_ACK_BIT = 6;
    localparam int ARB_BUS_REQ_BIT = 7;

    // ====================================================
    // reset values
    localparam logic PIN_RST = 1'b0;
    localparam logic HOLD_RST = 1'b1;

    // ====================================================
    // mode encodings
    typedef enum logic {
        PPC_THR_TTL = 1'b0,
        PPC_THR_SPECIAL = 1'b1
    } ppc_thresh_e;

    typedef enum logic {
        PPC_HB_ENABLE = 1'b0,
        PPC_HB_STROBE = 1'b1
    } ppc_hbmode_e;
endpackage

// ---- include/ppc_bank_if.sv ----
// carrier between the top and one bidirectional port bank
`timescale 1ns/1ns
interface ppc_bank_if #(parameter int W = 8);
    logic [W-1:0] dirOut;
    logic [W-1:0] latch;
    logic [W-1:0] openDrain;
    logic [W-1:0] altEn;
    logic [W-1:0] altOut;
    logic [W-1:0] pinIn;
    logic [W-1:0] pinOut;
    logic [W-1:0] pinOe;
    logic [W-1:0] readVal;

    modport bank (
        input dirOut,
        input latch,
        input openDrain,
        input altEn,
        input altOut,
        input pinIn,
        output pinOut,
        output pinOe,
        output readVal
    );

    modport ctrl (
        output dirOut,
        output latch,
        output openDrain,
        output altEn,
        output altOut,
        output pinIn,
        input pinOut,
        input pinOe,
        input readVal
    );
endinterface

// ---- hw/ppc_port_bank.sv ----
// one bidirectional port bank: direction, driver stage, alternate mux
`timescale 1ns/1ns
module ppc_port_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    ppc_bank_if.bank io
);
    import ppc_pkg::*;

    logic [WIDTH-1:0] drive;
    logic [WIDTH-1:0] altMask;
    logic [WIDTH-1:0] outReg;
    logic [WIDTH-1:0] outNext;
    logic [WIDTH-1:0] oeReg;
    logic [WIDTH-1:0] oeNext;
    logic [WIDTH-1:0] rdReg;
    logic [WIDTH-1:0] rdNext;

    // ========================================================
    // driver next state
    // alternate signal wins only on pins that are outputs
    always_comb begin
        altMask = io.altEn & io.dirOut & IMPL_MASK;
        drive = (altMask & io.altOut) | (~altMask & io.latch);
        // open drain only pulls low; high is left to the pull-up
        oeNext = io.dirOut & IMPL_MASK
            & (~io.openDrain | ~drive);
        outNext = drive & ~io.openDrain & io.dirOut & IMPL_MASK;
        rdNext = io.pinIn & IMPL_MASK;
    end

    // ========================================================
    // registered pin drivers and read value
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            outReg <= {WIDTH{PIN_RST}};
            oeReg <= {WIDTH{PIN_RST}};
            rdReg <= {WIDTH{PIN_RST}};
        end else begin
            outReg <= outNext;
            oeReg <= oeNext;
            rdReg <= rdNext;
        end
    end

    assign io.pinOut = outReg;
    assign io.pinOe = oeReg;
    assign io.readVal = rdReg;

    // ========================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    a_input_hiz: assert property (
        1'b1 |=> (io.pinOe & ~$past(io.dirOut)) == '0)
        else $error("input pin still driven");

    a_absent_quiet: assert property (
        ((io.pinOe | io.pinOut | io.readVal) & ~IMPL_MASK) == '0)
        else $error("absent bit is active");

    a_drain_nohigh: assert property (
        1'b1 |=> (io.pinOut & $past(io.openDrain)) == '0)
        else $error("open drain pin drove high");

    a_alt_select: assert property (
        1'b1 |=> ((io.pinOut ^ $past(io.altOut))
            & $past(altMask & ~io.openDrain)) == '0)
        else $error("alternate output not on pin");

    a_dir_enable: assert property (
        1'b1 |=> (~io.pinOe
            & $past(io.dirOut & ~io.openDrain & IMPL_MASK)) == '0)
        else $error("push-pull output not enabled");
endmodule

// ---- hw/ppc_port_pin_control.sv ----
// top of the port pin control block: five bidirectional ports, one input port
// Function
// - one direction bit per bidirectional pin
// - input pins have their driver switched off
// - ports are eight or sixteen pins wide, except the fifteen-pin timer port
// - push-pull or open-drain stage per pin
// - selectable TTL or special input threshold
// - sixteen-bit input-only port, no driver
// - input pin x is analog channel x
// - timer port bit fourteen is absent
// - timer port bit fifteen outputs system clock
// - bit twelve outputs high-byte enable or strobe
// - arbitration port chip selects, hold, acknowledge, request
`timescale 1ns/1ns
module ppc_port_pin_control (
    input wire logic sys_clk,
    input wire logic rstn,
    // arbitration byte port
    input wire logic [ppc_pkg::ARB_W-1:0] arbDir,
    input wire logic [ppc_pkg::ARB_W-1:0] arbLatch,
    input wire logic [ppc_pkg::ARB_W-1:0] arbOpenDrain,
    input wire logic [ppc_pkg::ARB_W-1:0] arbAltEn,
    input wire logic [ppc_pkg::ARB_W-1:0] arbPinIn,
    output logic [ppc_pkg::ARB_W-1:0] arbPinOut,
    output logic [ppc_pkg::ARB_W-1:0] arbPinOe,
    output logic [ppc_pkg::ARB_W-1:0] arbRead,
    input wire logic [ppc_pkg::ARB_CS_N-1:0] chipSelectN,
    input wire logic holdAcknowledgeN,
    input wire logic busRequestOutN,
    output logic holdRequestN,
    // first compare byte port
    input wire logic [ppc_pkg::CPA_W-1:0] cpaDir,
    input wire logic [ppc_pkg::CPA_W-1:0] cpaLatch,
    input wire logic [ppc_pkg::CPA_W-1:0] cpaOpenDrain,
    input wire logic [ppc_pkg::CPA_W-1:0] cpaAltEn,
    input wire logic [ppc_pkg::CPA_W-1:0] cpaAltOut,
    input wire ppc_pkg::ppc_thresh_e cpaThreshSel,
    input wire logic [ppc_pkg::CPA_W-1:0] cpaPinIn,
    output logic [ppc_pkg::CPA_W-1:0] cpaPinOut,
    output logic [ppc_pkg::CPA_W-1:0] cpaPinOe,
    output logic [ppc_pkg::CPA_W-1:0] cpaRead,
    output ppc_pkg::ppc_thresh_e cpaThresh,
    // second compare byte port
    input wire logic [ppc_pkg::CPB_W-1:0] cpbDir,
    input wire logic [ppc_pkg::CPB_W-1:0] cpbLatch,
    input wire logic [ppc_pkg::CPB_W-1:0] cpbOpenDrain,
    input wire logic [ppc_pkg::CPB_W-1:0] cpbAltEn,
    input wire logic [ppc_pkg::CPB_W-1:0] cpbAltOut,
    input wire ppc_pkg::ppc_thresh_e cpbThreshSel,
    input wire logic [ppc_pkg::CPB_W-1:0] cpbPinIn,
    output logic [ppc_pkg::CPB_W-1:0] cpbPinOut,
    output logic [ppc_pkg::CPB_W-1:0] cpbPinOe,
    output logic [ppc_pkg::CPB_W-1:0] cpbRead,
    output ppc_pkg::ppc_thresh_e cpbThresh,
    // capture/compare word port
    input wire logic [ppc_pkg::CAP_W-1:0] capDir,
    input wire logic [ppc_pkg::CAP_W-1:0] capLatch,
    input wire logic [ppc_pkg::CAP_W-1:0] capOpenDrain,
    input wire logic [ppc_pkg::CAP_W-1:0] capAltEn,
    input wire logic [ppc_pkg::CAP_W-1:0] capAltOut,
    input wire ppc_pkg::ppc_thresh_e capThreshSel,
    input wire logic [ppc_pkg::CAP_W-1:0] capPinIn,
    output logic [ppc_pkg::CAP_W-1:0] capPinOut,
    output logic [ppc_pkg::CAP_W-1:0] capPinOe,
    output logic [ppc_pkg::CAP_W-1:0] capRead,
    output ppc_pkg::ppc_thresh_e capThresh,
    // timer/serial port, fifteen pins
    input wire logic [ppc_pkg::TMR_W-1:0] tmrDir,
    input wire logic [ppc_pkg::TMR_W-1:0] tmrLatch,
    input wire logic [ppc_pkg::TMR_W-1:0] tmrOpenDrain,
    input wire logic [ppc_pkg::TMR_W-1:0] tmrAltEn,
    input wire logic [ppc_pkg::TMR_W-1:0] tmrAltOut,
    input wire ppc_pkg::ppc_thresh_e tmrThreshSel,
    input wire logic [ppc_pkg::TMR_W-1:0] tmrPinIn,
    output logic [ppc_pkg::TMR_W-1:0] tmrPinOut,
    output logic [ppc_pkg::TMR_W-1:0] tmrPinOe,
    output logic [ppc_pkg::TMR_W-1:0] tmrRead,
    output ppc_pkg::ppc_thresh_e tmrThresh,
    input wire ppc_pkg::ppc_hbmode_e highByteMode,
    input wire logic highByteEnableN,
    input wire logic highByteWriteStrobeN,
    // input-only port
    input wire logic [ppc_pkg::AIN_W-1:0] inputOnlyPortPin,
    input wire logic [ppc_pkg::AIN_SEL_W-1:0] analogChannelSel,
    output logic [ppc_pkg::AIN_W-1:0] inputOnlyRead,
    output logic analogChannelInput
);
    import ppc_pkg::*;

    // ========================================================
    // arbitration byte port
    ppc_bank_if #(.W(ARB_W)) arbIf ();

    // bus controller signals sit on their fixed bits; the hold
    // request bit is an input so its alternate output stays quiet
    assign arbIf.altOut = {busRequestOutN, holdAcknowledgeN,
        1'b1, chipSelectN};
    assign arbIf.dirOut = arbDir;
    assign arbIf.latch = arbLatch;
    assign arbIf.openDrain = arbOpenDrain;
    assign arbIf.altEn = arbAltEn;
    assign arbIf.pinIn = arbPinIn;

    ppc_port_bank #(.WIDTH(ARB_W), .IMPL_MASK(FULL8_MASK)) u_arb (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .io(arbIf.bank)
    );

    assign arbPinOut = arbIf.pinOut;
    assign arbPinOe = arbIf.pinOe;
    assign arbRead = arbIf.readVal;
    // external master's hold request, read from the pin each cycle
    assign holdRequestN = arbIf.readVal[ARB_HOLD_BIT];

    // ========================================================
    // first compare byte port
    ppc_bank_if #(.W(CPA_W)) cpaIf ();

    assign cpaIf.dirOut = cpaDir;
    assign cpaIf.latch = cpaLatch;
    assign cpaIf.openDrain = cpaOpenDrain;
    assign cpaIf.altEn = cpaAltEn;
    assign cpaIf.altOut = cpaAltOut;
    assign cpaIf.pinIn = cpaPinIn;

    ppc_port_bank #(.WIDTH(CPA_W), .IMPL_MASK(FULL8_MASK)) u_cpa (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .io(cpaIf.bank)
    );

    assign cpaPinOut = cpaIf.pinOut;
    assign cpaPinOe = cpaIf.pinOe;
    assign cpaRead = cpaIf.readVal;

    // ========================================================
    // second compare byte port
    ppc_bank_if #(.W(CPB_W)) cpbIf ();

    assign cpbIf.dirOut = cpbDir;
    assign cpbIf.latch = cpbLatch;
    assign cpbIf.openDrain = cpbOpenDrain;
    assign cpbIf.altEn = cpbAltEn;
    assign cpbIf.altOut = cpbAltOut;
    assign cpbIf.pinIn = cpbPinIn;

    ppc_port_bank #(.WIDTH(CPB_W), .IMPL_MASK(FULL8_MASK)) u_cpb (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .io(cpbIf.bank)
    );

    assign cpbPinOut = cpbIf.pinOut;
    assign cpbPinOe = cpbIf.pinOe;
    assign cpbRead = cpbIf.readVal;

    // ========================================================
    // capture/compare word port
    ppc_bank_if #(.W(CAP_W)) capIf ();

    assign capIf.dirOut = capDir;
    assign capIf.latch = capLatch;
    assign capIf.openDrain = capOpenDrain;
    assign capIf.altEn = capAltEn;
    assign capIf.altOut = capAltOut;
    assign capIf.pinIn = capPinIn;

    ppc_port_bank #(.WIDTH(CAP_W), .IMPL_MASK(FULL16_MASK)) u_cap (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .io(capIf.bank)
    );

    assign capPinOut = capIf.pinOut;
    assign capPinOe = capIf.pinOe;
    assign capRead = capIf.readVal;

    // ========================================================
    // timer/serial port
    ppc_bank_if #(.W(TMR_W)) tmrIf ();
    logic hbSignal;
    logic clkSel;

    // high-byte pin carries enable or write strobe per bus mode
    always_comb begin
        hbSignal = (highByteMode == PPC_HB_STROBE)
            ? highByteWriteStrobeN : highByteEnableN;
        tmrIf.altOut = tmrAltOut;
        tmrIf.altOut[TMR_HIGHBYTE_BIT] = hbSignal;
    end

    assign tmrIf.dirOut = tmrDir;
    assign tmrIf.latch = tmrLatch;
    assign tmrIf.openDrain = tmrOpenDrain;
    assign tmrIf.altEn = tmrAltEn;
    assign tmrIf.pinIn = tmrPinIn;

    ppc_port_bank #(.WIDTH(TMR_W), .IMPL_MASK(TMR_IMPL_MASK)) u_tmr (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .io(tmrIf.bank)
    );

    // the clock cannot pass through a flop at its own rate, so it is
    // muxed after the bank; only a push-pull stage can carry it
    assign clkSel = tmrAltEn[TMR_CLK_BIT] & tmrDir[TMR_CLK_BIT]
        & ~tmrOpenDrain[TMR_CLK_BIT];
    always_comb begin
        tmrPinOut = tmrIf.pinOut;
        tmrPinOut[TMR_CLK_BIT] = clkSel
            ? sys_clk : tmrIf.pinOut[TMR_CLK_BIT];
    end
    assign tmrPinOe = tmrIf.pinOe;
    assign tmrRead = tmrIf.readVal;

    // ========================================================
    // input thresholds, registered so the pad select is glitch free
    logic [3:0] thrReg;
    logic [3:0] thrNext;

    always_comb begin
        thrNext = {tmrThreshSel, capThreshSel,
            cpbThreshSel, cpaThreshSel};
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            thrReg <= {4{PPC_THR_TTL}};
        end else begin
            thrReg <= thrNext;
        end
    end

    assign cpaThresh = ppc_thresh_e'(thrReg[0]);
    assign cpbThresh = ppc_thresh_e'(thrReg[1]);
    assign capThresh = ppc_thresh_e'(thrReg[2]);
    assign tmrThresh = ppc_thresh_e'(thrReg[3]);

    // ========================================================
    // input-only port: no driver and no direction exist at all
    logic [AIN_W-1:0] ainReg;
    logic [AIN_W-1:0] ainNext;
    logic anaReg;
    logic anaNext;

    // channel x is simply pin x; digital read runs alongside
    always_comb begin
        ainNext = inputOnlyPortPin;
        anaNext = inputOnlyPortPin[analogChannelSel];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ainReg <= {AIN_W{PIN_RST}};
            anaReg <= PIN_RST;
        end else begin
            ainReg <= ainNext;
            anaReg <= anaNext;
        end
    end

    assign inputOnlyRead = ainReg;
    assign analogChannelInput = anaReg;

    // ========================================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_hbStrobe;
        tmrAltEn[TMR_HIGHBYTE_BIT] && tmrDir[TMR_HIGHBYTE_BIT]
            && !tmrOpenDrain[TMR_HIGHBYTE_BIT]
            && highByteMode == PPC_HB_STROBE;
    endsequence

    sequence s_clkAlt;
        tmrAltEn[TMR_CLK_BIT] && tmrDir[TMR_CLK_BIT]
            && !tmrOpenDrain[TMR_CLK_BIT];
    endsequence

    a_hb_strobe: assert property (
        s_hbStrobe |=> tmrPinOut[TMR_HIGHBYTE_BIT]
            == $past(highByteWriteStrobeN))
        else $error("high-byte pin does not follow strobe");

    a_clk_enable: assert property (
        s_clkAlt ##1 s_clkAlt |-> tmrPinOe[TMR_CLK_BIT])
        else $error("clock pin driver not enabled");

    a_thresh_follow: assert property (
        $changed(capThreshSel) |=> capThresh == $past(capThreshSel))
        else $error("threshold select not applied");

    a_ain_sample: assert property (
        1'b1 |=> inputOnlyRead == $past(inputOnlyPortPin))
        else $error("input-only port read mismatch");

    a_analog_pick: assert property (
        1'b1 |=> analogChannelInput
            == $past(inputOnlyPortPin[analogChannelSel]))
        else $error("analog channel not pin of same index");

    a_hold_path: assert property (
        !arbDir[ARB_HOLD_BIT] |=> holdRequestN
            == $past(arbPinIn[ARB_HOLD_BIT]) && !arbPinOe[ARB_HOLD_BIT])
        else $error("hold request not read from pin");
endmodule

// ---- tb/ppc_pin_partner.sv ----
// external circuitry model on one bidirectional port: pull-ups and drivers
`timescale 1ns/1ns
module ppc_pin_partner #(
    parameter int W = 8
) (
    input wire logic [W-1:0] pinOut,
    input wire logic [W-1:0] pinOe,
    input wire logic [W-1:0] extEn,
    input wire logic [W-1:0] extVal,
    output logic [W-1:0] pinLevel
);
    // ======
    // wire resolution
    // released lines float up through board pull-ups, so an open-drain
    // high or an undriven input never reads back a stale level
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pinOe[i]) begin
                pinLevel[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinLevel[i] = extVal[i];
            end else begin
                pinLevel[i] = 1'b1;
            end
        end
    end
endmodule

// ---- tb/ppc_port_pin_control_tb_top.sv ----
// self-checking bench for the port pin control block
`timescale 1ns/1ns
module ppc_port_pin_control_tb_top;
    import ppc_pkg::*;
    // ======
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] arbDir, arbLatch, arbOpenDrain, arbAltEn, arbPinIn;
    logic [7:0] arbPinOut, arbPinOe, arbRead, arbExtEn, arbExtVal;
    logic [4:0] chipSelectN;
    logic holdAcknowledgeN, busRequestOutN, holdRequestN;
    logic [7:0] cpaDir, cpaLatch, cpaOpenDrain, cpaAltEn, cpaAltOut;
    logic [7:0] cpaPinIn, cpaPinOut, cpaPinOe, cpaRead;
    logic [7:0] cpbDir, cpbLatch, cpbOpenDrain, cpbAltEn, cpbAltOut;
    logic [7:0] cpbPinIn, cpbPinOut, cpbPinOe, cpbRead;
    logic [15:0] capDir, capLatch, capOpenDrain, capAltEn, capAltOut;
    logic [15:0] capPinIn, capPinOut, capPinOe, capRead, capExtEn, capExtVal;
    logic [15:0] tmrDir, tmrLatch, tmrOpenDrain, tmrAltEn, tmrAltOut;
    logic [15:0] tmrPinIn, tmrPinOut, tmrPinOe, tmrRead;
    logic [15:0] inputOnlyPortPin, inputOnlyRead;
    ppc_thresh_e cpaThreshSel, cpbThreshSel, capThreshSel, tmrThreshSel;
    ppc_thresh_e cpaThresh, cpbThresh, capThresh, tmrThresh;
    ppc_hbmode_e highByteMode;
    logic highByteEnableN, highByteWriteStrobeN, analogChannelInput;
    logic [3:0] analogChannelSel;
    int errors = 0;
    int nChecks = 0;

    // ======
    // block and the circuitry on its pins
    ppc_port_pin_control uut (.*);
    ppc_pin_partner #(.W(8)) arbSide (.pinOut(arbPinOut), .pinOe(arbPinOe),
        .extEn(arbExtEn), .extVal(arbExtVal), .pinLevel(arbPinIn));
    ppc_pin_partner #(.W(16)) capSide (.pinOut(capPinOut), .pinOe(capPinOe),
        .extEn(capExtEn), .extVal(capExtVal), .pinLevel(capPinIn));

    // free-running system clock
    always #50 sys_clk = ~sys_clk;

    // ======
    // helpers
    task automatic chk(input logic [15:0] g, input logic [15:0] x,
                       input string m);
        nChecks++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask

    // one edge to register controls, one more for the pin readback
    task automatic settle;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // reference driver: returns {enable, value}
    function automatic logic [31:0] law(input logic [15:0] d, l, o, a, v);
        logic [15:0] drv;
        drv = (a & d & v) | (~(a & d) & l);
        return {d & (~o | ~drv), drv & ~o & d};
    endfunction

    task automatic summarize;
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ======
    // scenarios
    task automatic t_cap;
        logic [15:0] d[4] = '{16'hFFFF, 16'h00FF, 16'hA5A5, 16'hFFFF};
        logic [15:0] od[4] = '{16'h0000, 16'h0000, 16'h0F0F, 16'hFFFF};
        logic [31:0] e;
        logic [15:0] r;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            capDir <= d[i];
            capOpenDrain <= od[i];
            capLatch <= 16'h3C3C;
            capAltEn <= 16'hF000;
            capAltOut <= 16'h5A5A;
            capExtEn <= ~d[i];
            capExtVal <= 16'h1234;
            settle;
            e = law(d[i], 16'h3C3C, od[i], 16'hF000, 16'h5A5A);
            r = (e[31:16] & e[15:0]) | (~e[31:16] & ~d[i] & 16'h1234);
            r = r | (~e[31:16] & d[i]);
            chk(capPinOe, e[31:16], "cap enable");
            chk(capPinOut, e[15:0], "cap value");
            chk(capRead, r, "cap readback");
        end
    endtask

    task automatic t_bytes;
        logic [31:0] e;
        logic [31:0] f;
        @(posedge sys_clk);
        cpaDir <= 8'hF0;
        cpaLatch <= 8'h3C;
        cpaAltEn <= 8'h66;
        cpaAltOut <= 8'hA5;
        cpaPinIn <= 8'h96;
        cpbDir <= 8'hFF;
        cpbLatch <= 8'hC3;
        cpbOpenDrain <= 8'hF0;
        cpbAltEn <= 8'h0F;
        cpbAltOut <= 8'h5A;
        cpbPinIn <= 8'h69;
        settle;
        e = law(16'h00F0, 16'h003C, 16'h0000, 16'h0066, 16'h00A5);
        f = law(16'h00FF, 16'h00C3, 16'h00F0, 16'h000F, 16'h005A);
        chk(cpaPinOe, e[31:16], "cpa enable");
        chk(cpaPinOut, e[15:0], "cpa value");
        chk(cpaRead, 16'h0096, "cpa read");
        chk(cpbPinOe, f[31:16], "cpb enable");
        chk(cpbPinOut, f[15:0], "cpb value");
        chk(cpbRead, 16'h0069, "cpb read");
    endtask

    task automatic t_thr(input ppc_thresh_e t);
        @(posedge sys_clk);
        cpaThreshSel <= t;
        cpbThreshSel <= t;
        capThreshSel <= t;
        tmrThreshSel <= t;
        settle;
        chk(cpaThresh, t, "cpa threshold");
        chk(cpbThresh, t, "cpb threshold");
        chk(capThresh, t, "cap threshold");
        chk(tmrThresh, t, "tmr threshold");
    endtask

    task automatic t_ain;
        logic [15:0] p = 16'hC5A3;
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            inputOnlyPortPin <= p;
            analogChannelSel <= i[3:0];
            settle;
            chk(analogChannelInput, p[i], "analog channel");
        end
        chk(inputOnlyRead, p, "input-only read");
    endtask

    task automatic t_tmr;
        logic [31:0] e;
        @(posedge sys_clk);
        tmrDir <= 16'hFFFF;
        tmrLatch <= 16'hFFFF;
        tmrAltEn <= 16'h0FFF;
        tmrAltOut <= 16'h0A5A;
        tmrPinIn <= 16'hFFFF;
        settle;
        e = law(16'hFFFF, 16'hFFFF, 16'h0000, 16'h0FFF, 16'h0A5A);
        chk(tmrPinOe, e[31:16] & 16'hBFFF, "tmr enable");
        chk(tmrPinOut, e[15:0] & 16'hBFFF, "tmr value");
        chk(tmrRead, 16'hBFFF, "tmr read");
    endtask

    // open drain must block the clock, push-pull passes it
    task automatic t_clk;
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            tmrAltEn <= 16'h8000;
            tmrOpenDrain <= {k[0], 15'h0000};
            settle;
            #10; // clock pin is combinational: read it off the edge
            chk(tmrPinOut[15], 1'b0, "clock out low");
            @(posedge sys_clk);
            #10;
            chk(tmrPinOut[15], !k[0], "clock out high");
        end
    endtask

    task automatic t_hb;
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            tmrAltEn <= 16'h1000;
            tmrOpenDrain <= 16'h0000;
            highByteMode <= ppc_hbmode_e'(k[2]);
            highByteEnableN <= k[1];
            highByteWriteStrobeN <= k[0];
            settle;
            chk(tmrPinOut[12], k[2] ? k[0] : k[1], "high byte");
        end
    endtask

    task automatic t_arb;
        @(posedge sys_clk);
        arbDir <= 8'hDF;
        arbAltEn <= 8'hFF;
        // latch bit six high so only the alternate path gives zero there
        arbLatch <= 8'h40;
        chipSelectN <= 5'h15;
        holdAcknowledgeN <= 1'b0;
        busRequestOutN <= 1'b1;
        arbExtEn <= 8'h20;
        arbExtVal <= 8'h00;
        settle;
        chk(arbPinOut, 16'h0095, "arb alternate");
        chk(arbPinOe, 16'h00DF, "arb enable");
        chk(arbRead, 16'h0095, "arb read");
        chk(holdRequestN, 1'b0, "hold request");
        // alternate off: the latch drives again
        @(posedge sys_clk);
        arbExtEn <= 8'h00;
        arbAltEn <= 8'h00;
        arbDir <= 8'hFF;
        arbLatch <= 8'hA5;
        settle;
        chk(arbPinOut, 16'h00A5, "arb latch");
        chk(holdRequestN, 1'b1, "hold released");
    endtask

    // ======
    // main sequence
    initial begin
        {arbDir, arbLatch, arbOpenDrain, arbAltEn, arbExtEn} = '0;
        {arbExtVal, chipSelectN, holdAcknowledgeN, busRequestOutN} = '0;
        {cpaDir, cpaLatch, cpaOpenDrain, cpaAltEn, cpaAltOut, cpaPinIn} = '0;
        {cpbDir, cpbLatch, cpbOpenDrain, cpbAltEn, cpbAltOut, cpbPinIn} = '0;
        {capDir, capLatch, capOpenDrain, capAltEn, capAltOut} = '0;
        {capExtEn, capExtVal, tmrDir, tmrLatch, tmrOpenDrain} = '0;
        {tmrAltEn, tmrAltOut, tmrPinIn, inputOnlyPortPin} = '0;
        {highByteEnableN, highByteWriteStrobeN, analogChannelSel} = '0;
        cpaThreshSel = PPC_THR_TTL;
        cpbThreshSel = PPC_THR_TTL;
        capThreshSel = PPC_THR_TTL;
        tmrThreshSel = PPC_THR_TTL;
        highByteMode = PPC_HB_ENABLE;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(capPinOe, 16'h0000, "reset enable");
        @(posedge sys_clk);
        rstn <= 1'b1;
        t_cap;
        $display("cap port test done");
        t_bytes;
        $display("byte port test done");
        t_thr(PPC_THR_SPECIAL);
        t_thr(PPC_THR_TTL);
        $display("threshold test done");
        t_ain;
        $display("input-only test done");
        t_tmr;
        $display("timer port test done");
        t_clk;
        $display("clock output test done");
        t_hb;
        $display("high byte test done");
        t_arb;
        $display("arbitration test done");
        summarize;
    end

    // hang guard, about eighteen times the expected run
    initial begin
        #200000;
        errors++;
        summarize;
    end
endmodule
